// ==== logic/dam_pkg.sv ====
// constants shared by the dual converter output timing block
// assumes one system clock; the converter clock arrives as a synchronous level
// Summary of operation
// - each sample crosses seven pipeline stages, advancing on every converter clock half cycle
// - first channel result appears 5 cycles, second 5.5 cycles after sampling
// - both channels sampled together on each rising converter edge, one shared output bus
// - first channel data updates on rising edge, second channel on falling edge
// - channel flag high while first channel updates, low while second channel updates
// - redundant stage digits correct comparator offsets so no output code goes missing
// - results are offset binary, bit 7 most significant, zero input gives 1000 0000
// - power select 00 shutdown, 01 standby, 10 idle, 11 normal; bus driven only normal
// - leaving high impedance, the bus shows the most recently converted word, or 1000 0000 if none since reset
package dam_pkg;
   localparam int DAM_STAGES = 7;
   // half-cycle slots: seven stages, output latch slots for both channels
   localparam int DAM_DEPTH = 11;
   localparam int DAM_A_SLOT = 9;
   localparam int DAM_B_SLOT = 10;
   localparam int DAM_RES_W = 12;
   localparam int DAM_CODE_W = 10;
   localparam int DAM_OUT_W = 8;
   // full scale reference in residue units
   localparam logic signed [11:0] DAM_REF = 12'sh200;
   localparam logic signed [9:0] DAM_MID_CODE = 10'sh080;
   localparam logic signed [9:0] DAM_MAX_CODE = 10'sh0FF;
   localparam logic [7:0] DAM_OUT_RST = 8'h80;
   localparam logic [1:0] DAM_MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] DAM_MODE_STANDBY = 2'h1;
   localparam logic [1:0] DAM_MODE_IDLE = 2'h2;
   localparam logic [1:0] DAM_MODE_NORMAL = 2'h3;
endpackage

// ==== logic/dam_stage.sv ====
// one 1.5-bit pipeline stage: coarse digit and doubled residue
// assumes the residue stays within plus or minus the reference
`timescale 1ns/1ns
module dam_stage
   import dam_pkg::*;
#(
   parameter int RES_W = DAM_RES_W
) (
   input wire logic signed [RES_W-1:0] res_in,
   output logic signed [RES_W-1:0] res_out,
   output logic signed [1:0] digit
);
   localparam logic signed [RES_W-1:0] QTR = RES_W'(DAM_REF >>> 2);
   localparam logic signed [RES_W-1:0] REF = RES_W'(DAM_REF);

   // thresholds at a quarter scale leave margin so offsets are absorbed later
   always_comb begin
      if (res_in >= QTR) begin
         digit = 2'sb01;
         res_out = RES_W'((res_in <<< 1) - REF);
      end else if (res_in < -QTR) begin
         digit = 2'sb11;
         res_out = RES_W'((res_in <<< 1) + REF);
      end else begin
         digit = 2'sb00;
         res_out = RES_W'(res_in <<< 1);
      end
   end
endmodule // dam_stage

// ==== logic/dam_core.sv ====
// dual channel pipelined converter digital path with multiplexed output bus
// assumes conv_clk and power selects are synchronous to ref_clk and that
// conv_clk is much slower than ref_clk so each edge is seen
`timescale 1ns/1ns
module dam_core
   import dam_pkg::*;
#(
   parameter int RES_W = DAM_RES_W
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic conv_clk,
   input wire logic signed [RES_W-1:0] first_channel_sample,
   input wire logic signed [RES_W-1:0] second_channel_sample,
   input wire logic power_select_low,
   input wire logic power_select_high,
   output logic [DAM_OUT_W-1:0] result_bits,
   output logic [DAM_OUT_W-1:0] result_bits_oe,
   output logic first_channel_flag
);
   // ************************************************************
   // state
   // ************************************************************
   // one slot per half cycle of the converter clock:
   //   slot 0 holds the fresh samples with the code at mid scale
   //   slots 1 to 7 hold the doubled residue and running code after each stage
   //   slot 8 waits for the readout edge
   //   slot 9 is read out on a rising edge, slot 10 on the falling edge after it
   typedef struct packed {
      logic clk_q;
      logic [DAM_DEPTH-1:0] valid;
      logic [DAM_DEPTH-1:0][RES_W-1:0] res_a;
      logic [DAM_DEPTH-1:0][RES_W-1:0] res_b;
      logic [DAM_DEPTH-1:0][DAM_CODE_W-1:0] code_a;
      logic [DAM_DEPTH-1:0][DAM_CODE_W-1:0] code_b;
      logic [DAM_OUT_W-1:0] data;
      logic oe;
      logic flag;
   } dam_state_t;

   dam_state_t state_r;
   dam_state_t state_nxt;

   // ************************************************************
   // elaboration checks
   // ************************************************************
   // the residue is doubled before the reference comes off, so it needs the headroom
   if (RES_W < 12) begin : g_chk
      $error("dam_core: RES_W must hold twice the reference");
   end
   // a rising edge reads an odd slot, the falling edge after it the next slot
   if ((DAM_A_SLOT % 2) != 1 || DAM_B_SLOT != DAM_A_SLOT + 1) begin : g_chk_slot
      $error("dam_core: output slots must be an odd slot and the one after it");
   end
   // the output slots may only hold settled codes and must end the pipeline
   if (DAM_A_SLOT <= DAM_STAGES || DAM_B_SLOT != DAM_DEPTH - 1) begin : g_chk_depth
      $error("dam_core: output slots must follow the last stage and end the pipeline");
   end
   // the sum needs a sign bit and an overflow bit above the output word
   if (DAM_CODE_W < DAM_OUT_W + 2) begin : g_chk_code
      $error("dam_core: code width too small for the clamp");
   end
   // each stage settles one bit of the word below its most significant bit
   if (DAM_STAGES != DAM_OUT_W - 1) begin : g_chk_stages
      $error("dam_core: stage count does not match the output width");
   end
   // mid scale and full scale must match the output width for offset binary
   if (int'(DAM_MID_CODE) != 2 ** (DAM_OUT_W - 1)) begin : g_chk_mid
      $error("dam_core: mid code does not match the output width");
   end
   if (int'(DAM_MAX_CODE) != 2 ** DAM_OUT_W - 1) begin : g_chk_max
      $error("dam_core: full scale code does not match the output width");
   end

   // ************************************************************
   // stage arithmetic
   // ************************************************************
   logic signed [DAM_STAGES-1:0][RES_W-1:0] st_res_a;
   logic signed [DAM_STAGES-1:0][RES_W-1:0] st_res_b;
   logic signed [DAM_STAGES-1:0][1:0] st_dig_a;
   logic signed [DAM_STAGES-1:0][1:0] st_dig_b;

   for (genvar k = 0; k < DAM_STAGES; k++) begin : g_stage
      dam_stage #(.RES_W(RES_W)) u_a (
         .res_in(state_r.res_a[k]),
         .res_out(st_res_a[k]),
         .digit(st_dig_a[k])
      );
      dam_stage #(.RES_W(RES_W)) u_b (
         .res_in(state_r.res_b[k]),
         .res_out(st_res_b[k]),
         .digit(st_dig_b[k])
      );
   end

   // weighted digit sum; overlapping weights give the redundancy
   function automatic logic signed [DAM_CODE_W-1:0] add_digit(
      input logic signed [DAM_CODE_W-1:0] code,
      input logic signed [1:0] dig,
      input int k
   );
      logic signed [DAM_CODE_W-1:0] ext;
      ext = DAM_CODE_W'(dig);
      return DAM_CODE_W'(code + (ext <<< (DAM_STAGES - 1 - k)));
   endfunction

   // final comparator and clamp into offset binary
   function automatic logic [DAM_OUT_W-1:0] finish(
      input logic signed [DAM_CODE_W-1:0] code,
      input logic signed [RES_W-1:0] res
   );
      logic signed [DAM_CODE_W-1:0] c;
      c = res[RES_W-1] ? DAM_CODE_W'(code - 10'sd1) : code;
      if (c < 10'sd0) begin
         c = 10'sd0;
      end else if (c > DAM_MAX_CODE) begin
         c = DAM_MAX_CODE;
      end
      return c[DAM_OUT_W-1:0];
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   logic rise;
   logic fall;
   logic running;
   logic [1:0] mode;

   always_comb begin
      state_nxt = state_r;
      mode = {power_select_high, power_select_low};
      // a phase shorter than one ref_clk cycle can slip past this detector
      rise = conv_clk & ~state_r.clk_q;
      fall = ~conv_clk & state_r.clk_q;
      state_nxt.clk_q = conv_clk;
      running = 1'b0;
      state_nxt.oe = 1'b0;
      // standby keeps the clock tree running but not the converters, so only the flag moves
      unique case (mode)
         DAM_MODE_SHUTDOWN: begin
            running = 1'b0;
            state_nxt.oe = 1'b0;
         end
         DAM_MODE_STANDBY: begin
            running = 1'b0;
            state_nxt.oe = 1'b0;
         end
         // idle converts but keeps the bus released, so the newest word is ready
         DAM_MODE_IDLE: begin
            running = 1'b1;
            state_nxt.oe = 1'b0;
         end
         DAM_MODE_NORMAL: begin
            running = 1'b1;
            state_nxt.oe = 1'b1;
         end
      endcase

      // flag follows the converter clock
      if (rise) begin
         state_nxt.flag = 1'b1;
      end else if (fall) begin
         state_nxt.flag = 1'b0;
      end

      if (running && (rise || fall)) begin
         // every half cycle each slot moves on by one
         for (int i = 1; i < DAM_DEPTH; i++) begin
            state_nxt.valid[i] = state_r.valid[i-1];
            if (i <= DAM_STAGES) begin
               state_nxt.res_a[i] = st_res_a[i-1];
               state_nxt.res_b[i] = st_res_b[i-1];
               state_nxt.code_a[i] = add_digit(state_r.code_a[i-1], st_dig_a[i-1], i - 1);
               state_nxt.code_b[i] = add_digit(state_r.code_b[i-1], st_dig_b[i-1], i - 1);
            end else begin
               state_nxt.res_a[i] = state_r.res_a[i-1];
               state_nxt.res_b[i] = state_r.res_b[i-1];
               state_nxt.code_a[i] = state_r.code_a[i-1];
               state_nxt.code_b[i] = state_r.code_b[i-1];
            end
         end
         // both channels taken at the same rising edge
         state_nxt.valid[0] = rise;
         state_nxt.res_a[0] = first_channel_sample;
         state_nxt.res_b[0] = second_channel_sample;
         state_nxt.code_a[0] = DAM_MID_CODE;
         state_nxt.code_b[0] = DAM_MID_CODE;
      end

      // first channel on rising edge, ten half cycles after its sample
      if (running && rise && state_r.valid[DAM_A_SLOT]) begin
         state_nxt.data = finish(state_r.code_a[DAM_A_SLOT], state_r.res_a[DAM_A_SLOT]);
      end
      // second channel on falling edge, eleven half cycles after
      if (running && fall && state_r.valid[DAM_B_SLOT]) begin
         state_nxt.data = finish(state_r.code_b[DAM_B_SLOT], state_r.res_b[DAM_B_SLOT]);
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
         state_r.data <= DAM_OUT_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ************************************************************
   // pins
   // ************************************************************
   // data register is never cleared by mode changes, so the last word shows
   assign result_bits = state_r.data;
   // every driver enable comes from the one mode flop, so the pins never disagree
   for (genvar b = 0; b < DAM_OUT_W; b++) begin : g_oe
      assign result_bits_oe[b] = state_r.oe;
   end
   assign first_channel_flag = state_r.flag;
endmodule // dam_core

// ==== sim/dam_core_properties.sv ====
// checker on the pins of the dual converter output block
// assumes conv_clk phases of two or more ref_clk cycles
`timescale 1ns/1ns
module dam_chk
   import dam_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic conv_clk,
   input wire logic power_select_low,
   input wire logic power_select_high,
   input wire logic [DAM_OUT_W-1:0] result_bits,
   input wire logic [DAM_OUT_W-1:0] result_bits_oe,
   input wire logic first_channel_flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // edge detection costs one cycle, so allow one or two
   a_flag_rise: assert property ($rose(conv_clk) |-> ##[1:2] first_channel_flag)
      else $error("flag not high after clock rise");
   a_flag_fall: assert property ($fell(conv_clk) |-> ##[1:2] !first_channel_flag)
      else $error("flag not low after clock fall");
   a_flag_follows: assert property ($changed(first_channel_flag)
      |-> first_channel_flag == $past(conv_clk)) else $error("flag moved against clock");
   a_oe_normal: assert property ((power_select_high && power_select_low)[*2]
      |-> result_bits_oe == 8'hFF) else $error("bus not driven in normal mode");
   a_oe_off: assert property ((!(power_select_high && power_select_low))[*2]
      |-> result_bits_oe == 8'h00) else $error("bus driven outside normal mode");
   a_oe_uniform: assert property (result_bits_oe == 8'h00 || result_bits_oe == 8'hFF)
      else $error("bus enables disagree");
   a_hold_frozen: assert property ((!power_select_high)[*3] |-> $stable(result_bits))
      else $error("word changed while converters off");
   a_word_edge: assert property ($changed(result_bits) |->
      ($past(conv_clk, 1) != $past(conv_clk, 2)) || ($past(conv_clk, 2) != $past(conv_clk, 3)))
      else $error("word changed without a clock edge");
endmodule // dam_chk
bind dam_core dam_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .conv_clk(conv_clk),
   .power_select_low(power_select_low), .power_select_high(power_select_high),
   .result_bits(result_bits), .result_bits_oe(result_bits_oe),
   .first_channel_flag(first_channel_flag));

// ==== sim/dam_cap_model.sv ====
// capture logic model: makes the converter clock and pairs words with the flag
// assumes ref_clk is the shared system clock
`timescale 1ns/1ns
module dam_cap_model
   import dam_pkg::*;
(
   input wire logic ref_clk,
   input wire logic run,
   input wire logic first_channel_flag,
   input wire logic [DAM_OUT_W-1:0] result_bits,
   output logic conv_clk,
   output logic [DAM_OUT_W-1:0] word_a
);
   int ph = 0;
   initial conv_clk = 1'b0;
   // equal three-cycle phases keep the duty cycle at half
   always @(posedge ref_clk) begin
      ph = run ? ph + 1 : 0;
      if (ph == 3) begin
         ph = 0;
         conv_clk <= #1 ~conv_clk;
      end
   end
   always @(posedge ref_clk) if (first_channel_flag) word_a <= result_bits;
endmodule // dam_cap_model

// ==== sim/tb_top.sv ====
// self-checking bench for the dual converter output block
// assumes dam_core with default sample width
`timescale 1ns/1ns
module tb_top import dam_pkg::*;;
   typedef struct {logic signed [11:0] xa; logic signed [11:0] xb; logic [1:0] mode;
      logic [7:0] ea; logic [7:0] eb;} dam_row_t;
   dam_row_t rows [10] = '{'{12'h000, 12'h1FF, 2'h3, 8'h80, 8'hFF},
      '{12'hE00, 12'h004, 2'h3, 8'h00, 8'h81}, '{12'hFFC, 12'hFFF, 2'h2, 8'h7F, 8'h7F},
      '{12'h003, 12'h100, 2'h3, 8'h80, 8'hC0}, '{12'h1FC, 12'hF00, 2'h3, 8'hFF, 8'h40},
      '{12'h1FF, 12'h000, 2'h2, 8'hFF, 8'h80}, '{12'h004, 12'hE00, 2'h3, 8'h81, 8'h00},
      '{12'h100, 12'hFFC, 2'h3, 8'hC0, 8'h7F}, '{12'hF00, 12'h003, 2'h3, 8'h40, 8'h80},
      '{12'hFFF, 12'h1FC, 2'h3, 8'h7F, 8'hFF}};
   logic ref_clk = 1'b0, rst_n = 1'b0, run = 1'b0;
   logic power_select_low = 1'b1, power_select_high = 1'b1;
   logic signed [DAM_RES_W-1:0] sa = 12'h000, sb = 12'h000;
   logic conv_clk, flag;
   logic [7:0] rb, oe, wa;
   int err_total = 0, check_count = 0, cyc = 0;
   // 2.6 us of standby wake-up in 40 ns cycles
   localparam int WAKE_CYC = 65;
   dam_core DUT (.ref_clk(ref_clk), .rst_n(rst_n), .conv_clk(conv_clk),
      .first_channel_sample(sa), .second_channel_sample(sb),
      .power_select_low(power_select_low), .power_select_high(power_select_high),
      .result_bits(rb), .result_bits_oe(oe), .first_channel_flag(flag));
   dam_cap_model u_cap (.ref_clk(ref_clk), .run(run), .first_channel_flag(flag),
      .result_bits(rb), .conv_clk(conv_clk), .word_a(wa));
   always #20 ref_clk = ~ref_clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t mismatch got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      if (err_total == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // a hang costs at most this many cycles; the full run needs about 280
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      chk(rb, 8'h80);
      chk(oe, 8'h00);
      #1 rst_n = 1'b1;
      run = 1'b1;
      for (int k = 0; k < 15; k++) begin
         @(posedge conv_clk);
         {power_select_high, power_select_low} = rows[k % 10].mode;
         sa = rows[k % 10].xa;
         sb = rows[k % 10].xb;
         repeat (2) @(posedge ref_clk);
         #1;
         chk(oe, rows[k % 10].mode == 2'h3 ? 8'hFF : 8'h00);
         chk({7'h00, flag}, 8'h01);
         if (k >= 5) chk(rb, rows[(k - 5) % 10].ea);
         @(negedge conv_clk);
         repeat (2) @(posedge ref_clk);
         #1;
         chk({7'h00, flag}, 8'h00);
         if (k >= 5) chk(rb, rows[(k - 5) % 10].eb);
         if (k >= 6) chk(wa, rows[(k - 5) % 10].ea);
      end
      // standby then shutdown with the clock still running: word must hold
      for (int m = 1; m >= 0; m--) begin
         {power_select_high, power_select_low} = m[1:0];
         repeat (30) @(posedge ref_clk);
         #1;
         chk(rb, rows[9].eb);
         chk(oe, 8'h00);
      end
      run = 1'b0;
      {power_select_high, power_select_low} = 2'h3;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(oe, 8'hFF);
      chk(rb, rows[9].eb);
      // reset in mid-run with the clock parked low, then a restart after wake-up
      rst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(rb, DAM_OUT_RST);
      chk(oe, 8'h00);
      chk({7'h00, flag}, 8'h00);
      rst_n = 1'b1;
      repeat (WAKE_CYC) @(posedge ref_clk);
      #1;
      run = 1'b1;
      sa = rows[1].xa;
      sb = rows[1].xb;
      // words inside the latency are stale: the reset code must still stand
      repeat (5) @(posedge conv_clk);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(rb, DAM_OUT_RST);
      @(posedge conv_clk);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(rb, rows[1].ea);
      @(negedge conv_clk);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(rb, rows[1].eb);
      chk(wa, rows[1].ea);
      stop_test();
   end
endmodule // tb_top
